// ==== tmo_pkg.sv ====
// package for the timer-one control block: register layout, encodings, field and source types
package tmo_pkg;
  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [3:0] TMO_ADDR_CTRL = 4'h0;
  localparam logic [3:0] TMO_ADDR_COUNT = 4'h1;
  localparam logic [15:0] TMO_CTRL_RESET = 16'h0000;
  localparam logic [15:0] TMO_CTRL_MASK = 16'ha376; // implemented bits only
  localparam int TMO_BIT_RUN = 15;
  localparam int TMO_BIT_IDLE = 13;
  localparam int TMO_BIT_ECS_LO = 8;
  localparam int TMO_BIT_GATE = 6;
  localparam int TMO_BIT_PS_LO = 4;
  localparam int TMO_BIT_SYNC = 2;
  localparam int TMO_BIT_CS = 1;
  // ----------------------------------------------------------------
  // encodings
  // ----------------------------------------------------------------
  localparam logic [1:0] TMO_ECS_SEC = 2'h0;
  localparam logic [1:0] TMO_ECS_PIN = 2'h1;
  localparam logic [1:0] TMO_ECS_RC = 2'h2;
  localparam logic [7:0] TMO_DIV1_LAST = 8'h00;
  localparam logic [7:0] TMO_DIV8_LAST = 8'h07;
  localparam logic [7:0] TMO_DIV64_LAST = 8'h3f;
  localparam logic [7:0] TMO_DIV256_LAST = 8'hff;

  // decoded control fields
  typedef struct packed {
    logic run;
    logic idle_stop;
    logic [1:0] ext_clock_select;
    logic gated_accumulate_enable;
    logic [1:0] prescale_select;
    logic external_sync_select;
    logic clock_source_select;
  } tmo_ctrl_s;

  // source edge selector state
  typedef enum logic [1:0] {
    TMO_SRC_INT = 2'b00,
    TMO_SRC_EXT = 2'b01,
    TMO_SRC_GATED = 2'b10
  } tmo_src_e;
endpackage : tmo_pkg

// ==== tmo_timer.sv ====
// timer-one control register and sixteen-bit count logic
//
// The placing of the registers and the strobed register port were decided locally.
`timescale 1ns/100ps
module tmo_timer
  import tmo_pkg::*;
(
  input wire logic clk, // 40 mhz system clock
  input wire logic sys_rst, // synchronous reset, active high
  input wire logic clk_en, // freezes all state when low
  input wire logic [3:0] addr, // register index
  input wire logic [15:0] wdata, // write data
  input wire logic wr_stb, // write strobe
  input wire logic rd_stb, // read strobe
  output logic [15:0] rdata, // read data, one cycle after rd_stb
  input wire logic idle_mode, // device is in idle mode
  input wire logic inst_clk_tick, // instruction clock enable, fosc/2
  input wire logic secondary_oscillator, // secondary oscillator level
  input wire logic low_power_rc_oscillator, // low-power rc level
  input wire logic external_clock_pin, // external pin clock level
  input wire logic gate_in, // gate for accumulation
  output logic [15:0] count, // timer count
  output logic counting // timer advancing is allowed
);
  // ----------------------------------------------------------------
  // control register
  // ----------------------------------------------------------------
  logic [15:0] ctrl_q;
  tmo_ctrl_s c;
  logic [15:0] count_q;

  // write only implemented bits; others stay zero
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ctrl_q <= TMO_CTRL_RESET;
    end else if (clk_en && wr_stb && addr == TMO_ADDR_CTRL) begin
      ctrl_q <= wdata & TMO_CTRL_MASK;
    end
  end

  assign c.run = ctrl_q[TMO_BIT_RUN];
  assign c.idle_stop = ctrl_q[TMO_BIT_IDLE];
  assign c.ext_clock_select = ctrl_q[TMO_BIT_ECS_LO +: 2];
  assign c.gated_accumulate_enable = ctrl_q[TMO_BIT_GATE];
  assign c.prescale_select = ctrl_q[TMO_BIT_PS_LO +: 2];
  assign c.external_sync_select = ctrl_q[TMO_BIT_SYNC];
  assign c.clock_source_select = ctrl_q[TMO_BIT_CS];

  // ----------------------------------------------------------------
  // register read
  // ----------------------------------------------------------------
  // read data stands one cycle after the strobe; unmapped reads zero
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rdata <= 16'h0000;
    end else if (clk_en) begin
      if (rd_stb && addr == TMO_ADDR_CTRL) begin
        rdata <= ctrl_q;
      end else if (rd_stb && addr == TMO_ADDR_COUNT) begin
        rdata <= count_q;
      end else begin
        rdata <= 16'h0000;
      end
    end
  end

  // ----------------------------------------------------------------
  // external source selection and synchronisation
  // ----------------------------------------------------------------
  logic ext_raw;
  logic sync1_q;
  logic sync2_q;
  logic ext_prev_q;
  logic ext_lvl;
  logic ext_tick;

  // reserved code 11 falls to the secondary oscillator
  always_comb begin
    case (c.ext_clock_select)
      TMO_ECS_PIN: ext_raw = external_clock_pin;
      TMO_ECS_RC: ext_raw = low_power_rc_oscillator;
      default: ext_raw = secondary_oscillator;
    endcase
  end

  // two-stage synchroniser
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
    end else if (clk_en) begin
      sync1_q <= ext_raw;
      sync2_q <= sync1_q;
    end
  end

  // raw path only skips the synchroniser stages
  assign ext_lvl = c.external_sync_select ? sync2_q : ext_raw;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ext_prev_q <= 1'b0;
    end else if (clk_en) begin
      ext_prev_q <= ext_lvl;
    end
  end

  assign ext_tick = ext_lvl & ~ext_prev_q;

  // ----------------------------------------------------------------
  // source tick and run enable
  // ----------------------------------------------------------------
  tmo_src_e src;
  logic src_tick;
  logic run_ok;

  always_comb begin
    if (c.clock_source_select) begin
      src = TMO_SRC_EXT;
    end else if (c.gated_accumulate_enable) begin
      src = TMO_SRC_GATED;
    end else begin
      src = TMO_SRC_INT;
    end
  end

  always_comb begin
    case (src)
      TMO_SRC_EXT: src_tick = ext_tick;
      TMO_SRC_GATED: src_tick = inst_clk_tick & gate_in;
      TMO_SRC_INT: src_tick = inst_clk_tick;
      default: src_tick = 1'b0;
    endcase
  end

  assign run_ok = c.run && !(c.idle_stop && idle_mode);
  assign counting = run_ok;

  // ----------------------------------------------------------------
  // prescaler
  // ----------------------------------------------------------------
  logic [7:0] ps_q;
  logic [7:0] ps_last;
  logic ps_tick;

  always_comb begin
    case (c.prescale_select)
      2'h0: ps_last = TMO_DIV1_LAST;
      2'h1: ps_last = TMO_DIV8_LAST;
      2'h2: ps_last = TMO_DIV64_LAST;
      default: ps_last = TMO_DIV256_LAST;
    endcase
  end

  assign ps_tick = run_ok && src_tick && (ps_q >= ps_last);

  // prescaler clears when the run bit is off; an idle stop holds it
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ps_q <= 8'h00;
    end else if (clk_en) begin
      if (!c.run) begin
        ps_q <= 8'h00;
      end else if (run_ok && src_tick) begin
        ps_q <= ps_tick ? 8'h00 : ps_q + 8'h01;
      end
    end
  end

  // ----------------------------------------------------------------
  // counter
  // ----------------------------------------------------------------
  // count may also be written by software
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      count_q <= 16'h0000;
    end else if (clk_en) begin
      if (wr_stb && addr == TMO_ADDR_COUNT) begin
        count_q <= wdata;
      end else if (ps_tick) begin
        count_q <= count_q + 16'h0001;
      end
    end
  end

  assign count = count_q;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_idle_halt;
    @(posedge clk) disable iff (sys_rst)
    (clk_en && c.idle_stop && idle_mode && !(wr_stb && addr == TMO_ADDR_COUNT))
      |=> count_q == $past(count_q);
  endproperty
  a_idle_halt: assert property (p_idle_halt) else $error("count moved in idle");

  property p_idle_run;
    @(posedge clk) disable iff (sys_rst)
    (c.run && !c.idle_stop && idle_mode) |-> counting;
  endproperty
  a_idle_run: assert property (p_idle_run) else $error("timer stopped in idle");

  property p_ext_pin;
    @(posedge clk) disable iff (sys_rst)
    (c.ext_clock_select == TMO_ECS_PIN) |-> ext_raw == external_clock_pin;
  endproperty
  a_ext_pin: assert property (p_ext_pin) else $error("pin source not chosen");

  property p_ext_rc;
    @(posedge clk) disable iff (sys_rst)
    (c.ext_clock_select == TMO_ECS_RC) |-> ext_raw == low_power_rc_oscillator;
  endproperty
  a_ext_rc: assert property (p_ext_rc) else $error("low-power rc source not chosen");

  property p_gate;
    @(posedge clk) disable iff (sys_rst)
    (!c.clock_source_select && c.gated_accumulate_enable && !gate_in) |-> !src_tick;
  endproperty
  a_gate: assert property (p_gate) else $error("gated tick with gate low");

  property p_gate_ignored;
    @(posedge clk) disable iff (sys_rst)
    c.clock_source_select |-> src_tick == ext_tick;
  endproperty
  a_gate_ignored: assert property (p_gate_ignored) else $error("gate used on ext");

  property p_div8;
    @(posedge clk) disable iff (sys_rst)
    (clk_en && ps_tick && c.prescale_select == 2'h1 && $past(c.prescale_select) == 2'h1)
      |-> ps_q == TMO_DIV8_LAST;
  endproperty
  a_div8: assert property (p_div8) else $error("divide by eight wrong");

  property p_sync;
    @(posedge clk) disable iff (sys_rst)
    (clk_en && $past(clk_en, 2) && $past(clk_en) && c.external_sync_select
      && $past(c.external_sync_select))
      |-> ext_lvl == $past(ext_raw, 2) || $past(c.ext_clock_select, 2) != c.ext_clock_select;
  endproperty
  a_sync: assert property (p_sync) else $error("sync path delay wrong");

  property p_mask;
    @(posedge clk) disable iff (sys_rst)
    (ctrl_q & ~TMO_CTRL_MASK) == 16'h0000;
  endproperty
  a_mask: assert property (p_mask) else $error("unimplemented bit set");

  property p_stop;
    @(posedge clk) disable iff (sys_rst)
    (!c.run && clk_en && !(wr_stb && addr == TMO_ADDR_COUNT)) |=> count_q == $past(count_q);
  endproperty
  a_stop: assert property (p_stop) else $error("count moved while stopped");

  property p_step;
    @(posedge clk) disable iff (sys_rst)
    (clk_en && ps_tick && !(wr_stb && addr == TMO_ADDR_COUNT))
      |=> count_q == $past(count_q) + 16'h0001;
  endproperty
  a_step: assert property (p_step) else $error("count did not step by one");

  property p_ext_sec;
    @(posedge clk) disable iff (sys_rst)
    (c.ext_clock_select == TMO_ECS_SEC) |-> ext_raw == secondary_oscillator;
  endproperty
  a_ext_sec: assert property (p_ext_sec) else $error("secondary source not chosen");

  property p_raw;
    @(posedge clk) disable iff (sys_rst)
    (c.clock_source_select && !c.external_sync_select) |-> ext_lvl == ext_raw;
  endproperty
  a_raw: assert property (p_raw) else $error("raw path delayed");

  property p_internal;
    @(posedge clk) disable iff (sys_rst)
    (!c.clock_source_select && !c.gated_accumulate_enable) |-> src_tick == inst_clk_tick;
  endproperty
  a_internal: assert property (p_internal) else $error("internal tick not used");

  property p_div1;
    @(posedge clk) disable iff (sys_rst)
    (clk_en && run_ok && src_tick && c.prescale_select == 2'h0) |-> ps_tick;
  endproperty
  a_div1: assert property (p_div1) else $error("divide by one wrong");

  property p_div64;
    @(posedge clk) disable iff (sys_rst)
    (clk_en && ps_tick && c.prescale_select == 2'h2 && $past(c.prescale_select) == 2'h2)
      |-> ps_q == TMO_DIV64_LAST;
  endproperty
  a_div64: assert property (p_div64) else $error("divide by sixty-four wrong");

  property p_run_off;
    @(posedge clk) disable iff (sys_rst)
    !c.run |-> !counting;
  endproperty
  a_run_off: assert property (p_run_off) else $error("counting while stopped");

  property p_rd_ctrl;
    @(posedge clk) disable iff (sys_rst)
    (clk_en && rd_stb && addr == TMO_ADDR_CTRL) |=> rdata == $past(ctrl_q);
  endproperty
  a_rd_ctrl: assert property (p_rd_ctrl) else $error("control read wrong");

  property p_rd_idle;
    @(posedge clk) disable iff (sys_rst)
    (clk_en && !rd_stb) |=> rdata == 16'h0000;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not released");

  property p_freeze;
    @(posedge clk) disable iff (sys_rst)
    !clk_en |=> count_q == $past(count_q) && ctrl_q == $past(ctrl_q);
  endproperty
  a_freeze: assert property (p_freeze) else $error("state moved while frozen");
endmodule : tmo_timer

// ==== timer1_control_fields_test.sv ====
// self-checking testbench for the timer-one control and count block
`timescale 1ns/100ps
module timer1_control_fields_test;
  import tmo_pkg::*;
  // ----------------------------------------------------------------
  // stimulus signals and bookkeeping
  // ----------------------------------------------------------------
  logic clk, sys_rst, clk_en, wr_stb, rd_stb, idle_mode, inst_clk_tick, gate_in, counting;
  logic [3:0] addr;
  logic [15:0] wdata, rdata, count, rd_v;
  logic [2:0] src; // bit 0 secondary, bit 1 pin, bit 2 low-power rc
  int n_errors, checks;
  int divs[4] = '{1, 8, 64, 256};

  // device under test
  tmo_timer dut (.clk(clk), .sys_rst(sys_rst), .clk_en(clk_en), .addr(addr), .wdata(wdata),
    .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .idle_mode(idle_mode),
    .inst_clk_tick(inst_clk_tick), .secondary_oscillator(src[0]),
    .low_power_rc_oscillator(src[2]), .external_clock_pin(src[1]), .gate_in(gate_in),
    .count(count), .counting(counting));

  // 40 mhz clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_stb <= 1'b1;
    @(posedge clk);
    wr_stb <= 1'b0;
  endtask : wr

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a);
    @(posedge clk);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge clk);
    rd_stb <= 1'b0;
    #1 rd_v = rdata;
  endtask : rd

  task automatic ticks(input int n);
    repeat (n) begin
      @(posedge clk);
      inst_clk_tick <= 1'b1;
      @(posedge clk);
      inst_clk_tick <= 1'b0;
    end
  endtask : ticks

  // rising edges on one source level, with room for the two-flop synchroniser
  task automatic src_pulse(input int k, input int n);
    repeat (n) begin
      @(posedge clk);
      src[k] <= 1'b1;
      repeat (3) @(posedge clk);
      src[k] <= 1'b0;
      repeat (3) @(posedge clk);
    end
    repeat (5) @(posedge clk);
  endtask : src_pulse

  task automatic chk_count(input string name, input logic [15:0] exp);
    repeat (3) @(posedge clk);
    #1 check(name, count, exp);
  endtask : chk_count

  // stop, clear the count, then load the new control word
  task automatic restart(input logic [15:0] c);
    wr(TMO_ADDR_CTRL, 16'h0000);
    wr(TMO_ADDR_COUNT, 16'h0000);
    wr(TMO_ADDR_CTRL, c);
  endtask : restart

  task automatic finish_test;
    $display("checks %0d errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : finish_test

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_regs;
    rd(TMO_ADDR_CTRL);
    check("ctrl reset", rd_v, TMO_CTRL_RESET);
    wr(TMO_ADDR_CTRL, 16'hfdff); // all bits but the reserved source code
    rd(TMO_ADDR_CTRL);
    check("ctrl mask", rd_v, TMO_CTRL_MASK & 16'hfdff);
    wr(TMO_ADDR_CTRL, 16'h0000);
    rd(TMO_ADDR_CTRL);
    check("ctrl clear", rd_v, 16'h0000);
    @(posedge clk);
    #1 check("read released", rdata, 16'h0000);
  endtask : t_regs

  task automatic t_run;
    restart(16'h8000);
    #1 check("counting on", {15'h0000, counting}, 16'h0001);
    ticks(5);
    chk_count("run count", 16'h0005);
    wr(TMO_ADDR_CTRL, 16'h0000);
    ticks(3);
    chk_count("stopped count", 16'h0005);
    rd(TMO_ADDR_COUNT);
    check("count read", rd_v, 16'h0005);
  endtask : t_run

  // clock enable low freezes the count; run at divide by one, so the prescaler hold is not exercised
  task automatic t_freeze;
    restart(16'h8000);
    @(posedge clk);
    clk_en <= 1'b0;
    ticks(2);
    chk_count("freeze hold", 16'h0000);
    @(posedge clk);
    clk_en <= 1'b1;
    ticks(1);
    chk_count("freeze resume", 16'h0001);
  endtask : t_freeze

  // one tick short of the second prescaler pulse, then the pulse itself
  task automatic t_prescale;
    for (int p = 0; p < 4; p++) begin
      restart(16'h8000 | 16'(p << 4));
      ticks(2 * divs[p] - 1);
      chk_count("prescale one", 16'h0001);
      ticks(1);
      chk_count("prescale two", 16'h0002);
    end
  endtask : t_prescale

  task automatic t_idle;
    restart(16'ha000);
    @(posedge clk);
    idle_mode <= 1'b1;
    ticks(3);
    chk_count("idle halt", 16'h0000);
    check("idle counting", {15'h0000, counting}, 16'h0000);
    @(posedge clk);
    idle_mode <= 1'b0;
    ticks(2);
    chk_count("idle resume", 16'h0002);
    restart(16'h8000);
    @(posedge clk);
    idle_mode <= 1'b1;
    ticks(3);
    chk_count("idle continue", 16'h0003);
    @(posedge clk);
    idle_mode <= 1'b0;
  endtask : t_idle

  task automatic t_gate;
    restart(16'h8040);
    ticks(3);
    chk_count("gate low", 16'h0000);
    @(posedge clk);
    gate_in <= 1'b1;
    ticks(3);
    chk_count("gate high", 16'h0003);
    @(posedge clk);
    gate_in <= 1'b0;
  endtask : t_gate

  // each external source, gate bit set but ignored, sync on odd codes
  task automatic t_ext;
    for (int e = 0; e < 3; e++) begin // codes 00 to 10 only
      restart(16'h8042 | 16'(e << 8) | 16'(e % 2 * 4));
      ticks(2);
      chk_count("ext ignores tick", 16'h0000);
      src_pulse((e + 1) % 3, 2);
      chk_count("ext other source", 16'h0000);
      src_pulse(e, 3);
      chk_count("ext edges", 16'h0003);
    end
  endtask : t_ext

  // ----------------------------------------------------------------
  // main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    sys_rst = 1'b1;
    clk_en = 1'b1;
    addr = 4'h0;
    wdata = 16'h0000;
    wr_stb = 1'b0;
    rd_stb = 1'b0;
    idle_mode = 1'b0;
    inst_clk_tick = 1'b0;
    gate_in = 1'b0;
    src = 3'h0;
    n_errors = 0;
    checks = 0;
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    t_regs();
    t_run();
    t_freeze();
    t_prescale();
    t_idle();
    t_gate();
    t_ext();
    finish_test();
  end

  // the run needs under two thousand cycles; cut it off well beyond that
  initial begin
    #1000000;
    n_errors++;
    finish_test();
  end
endmodule : timer1_control_fields_test
